// ==== bench/flag_source.sv ====
// peripheral flag source model: bench strobes become set pulses
`timescale 1ns/10ps
module flag_source (
  // clock
  input wire logic clk_i,
  // bench requests and set pulses toward the evaluator
  input wire logic [6:0] req_i,
  output logic [6:0] set_o
);
  ////////////////////////////////////////////////////////////////
  // registered like a real timer or converter completion strobe
  always_ff @(posedge clk_i) begin
    set_o <= req_i;
  end
endmodule

// ==== bench/tb_skip_condition_evaluator.sv ====
// self-checking bench of the skip condition evaluator
`timescale 1ns/10ps
module tb_skip_condition_evaluator;
  import skip_eval_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0, imm_i = '0, acc_i = '0, pointed_memory_nibble_i = '0, exec_op_i = 4'hF;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic wb_ack_o, exec_valid_i = 0, imm_valid_i = 0, exec_skipped_o, skip_valid_o, skip_o, skip_pending_o;
  logic ext0_pin_i = 0, ext1_pin_i = 0, powerdown_flag_i = 0;
  logic [6:0] flag_set_i, request_flags_o, req = '0;
  int mismatches = 0;
  int samples_checked = 0;
  logic exp_q[$];
  int fb[7] = '{0, 1, 5, 6, 2, 3, 4};
  int rg[7] = '{0, 0, 4, 4, 0, 0, 4};
  int eb[7] = '{0, 1, 2, 3, 2, 3, 0};
  always #5 clk_i = ~clk_i;
  flag_source src (.clk_i, .req_i(req), .set_o(flag_set_i));
  skip_condition_evaluator dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .exec_valid_i, .exec_op_i, .imm_valid_i, .imm_i, .acc_i,
    .pointed_memory_nibble_i, .exec_skipped_o, .skip_valid_o, .skip_o, .skip_pending_o, .flag_set_i,
    .ext0_pin_i, .ext1_pin_i, .powerdown_flag_i, .request_flags_o);
  ////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // decision watcher: oldest note against each decision pulse
  always @(posedge clk_i) begin
    if (skip_valid_o === 1'b1) begin
      if (exp_q.size() > 0) check_val(skip_o, exp_q.pop_front(), "skip");
      else check_val(skip_o, 0, "decision on a no-op");
    end
  end
  // classic single cycle, waits for ack with a bounded count
  task automatic wb(input logic we, input logic [5:0] adr, input logic [3:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {28'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) check_val(0, 1, "ack timeout");
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask
  // pulse one peripheral set, wait until the flag is visible
  task automatic raise(input int b);
    @(posedge clk_i);
    req <= 7'(1 << b);
    @(posedge clk_i);
    req <= '0;
    repeat (2) @(posedge clk_i);
  endtask
  // one instruction; a skip is consumed by a suppressed ext1 test
  task automatic run(input logic [3:0] op, input logic [3:0] a, input logic [3:0] m, input logic dec, input logic sk);
    if (dec) exp_q.push_back(sk);
    @(posedge clk_i);
    req <= '0;
    exec_valid_i <= 1;
    exec_op_i <= op;
    acc_i <= a;
    pointed_memory_nibble_i <= m;
    @(posedge clk_i);
    exec_valid_i <= 0;
    if (op == 4'h0) begin
      imm_valid_i <= 1;
      imm_i <= m;
      @(posedge clk_i);
      imm_valid_i <= 0;
    end
    repeat (2) @(posedge clk_i);
    #1 check_val(skip_pending_o, sk, "pending");
    if (sk) begin
      @(posedge clk_i);
      exec_valid_i <= 1;
      exec_op_i <= 4'h3;
      #1 check_val(exec_skipped_o, 1, "suppress");
      @(posedge clk_i);
      exec_valid_i <= 0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // bounded run: far above the expected few hundred cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    check_val(0, 1, "watchdog");
    stop_test();
  end
  initial begin
    logic [3:0] a, v;
    void'($urandom(32'hCCF76384));
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 6; i++) begin
      v = 4'($urandom);
      wb(1, 6'(i * 4), v, rd);
      wb(0, 6'(i * 4), 4'h0, rd);
      check_val(rd, i < 4 ? {28'h0, v} : 32'h0, "reg readback");
    end
    wb(0, 6'h24, 4'h0, rd);
    check_val(rd, 0, "unmapped");
    $display("register test done");
    for (int op = 0; op < 2; op++) for (int i = 0; i < 8; i++) begin
      a = i[2] ? 4'($urandom) : (i[1] ? 4'hF : 4'h0);
      v = i[0] ? a : 4'(a + 1 + $urandom % 15);
      run(4'(op), a, v, 1, i[0]);
    end
    $display("compare test done");
    for (int i = 0; i < 7; i++) for (int e = 0; e < 2; e++) for (int f = 0; f < 2; f++) begin
      if (f) raise(fb[i]);
      v = 4'($urandom);
      v[eb[i]] = e[0];
      wb(1, 6'(rg[i]), v, rd);
      run(4'(i + 2), 4'h0, 4'h0, !e, f && !e);
      check_val(request_flags_o[fb[i]], f && e, "flag after test");
    end
    wb(0, 6'h10, 4'h0, rd);
    check_val(rd, 32'h0000007F, "flag status");
    $display("flag test done");
    wb(1, 6'h00, 4'h0, rd);
    raise(0);
    @(posedge clk_i);
    req <= 7'h01;
    run(4'h2, 4'h0, 4'h0, 1, 1);
    check_val(request_flags_o[0], 1, "set lost");
    for (int p = 0; p < 2; p++) for (int l = 0; l < 4; l++) begin
      v = 4'($urandom);
      v[2] = l[1];
      wb(1, p ? 6'h0C : 6'h08, v, rd);
      ext0_pin_i <= p ? ~l[0] : l[0];
      ext1_pin_i <= p ? l[0] : ~l[0];
      run(p ? 4'hA : 4'h9, 4'h0, 4'h0, 1, l[0] == l[1]);
    end
    $display("pin test done");
    raise(1);
    for (int l = 0; l < 2; l++) begin
      powerdown_flag_i <= l[0];
      run(4'hB, 4'h0, 4'h0, 1, l[0]);
    end
    check_val(request_flags_o[1], 1, "suppressed test cleared");
    check_val(exp_q.size(), 0, "missing decisions");
    wb(0, 6'h14, 4'h0, rd);
    check_val(rd, 32'h00000002, "skip status");
    $display("powerdown test done");
    stop_test();
  end
endmodule

// ==== design/request_flag_bank.sv ====
// sticky request flags: peripheral sets, successful tests clear
`timescale 1ns/10ps
module request_flag_bank #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // set and clear pulses
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // flag levels
  output logic [WIDTH-1:0] flags_o
);
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // set wins so a request arriving during its own clear survives
  assign flags_next = (flags_reg & ~clr_i) | set_i; // [RULE14]
  assign flags_o = flags_reg;

  // flag storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule

// ==== design/skip_condition_evaluator.sv ====
// skip decision logic for compare-and-skip and flag-test instructions
// Operation
// (RULE1) immediate compare: two words, skip if equal
// (RULE2) memory compare: skip if accumulator equals nibble
// (RULE3) ext0 test: gated, skip and clear flag
// (RULE4) ext1 test: gated, skip and clear flag
// (RULE5) conversion test: gated, skip, clear, else no-op
// (RULE6) serial test: gated, skip, clear, else no-op
// (RULE7) timer1 test: gated, skip, clear, else no-op
// (RULE8) timer2 test: gated, skip, clear, else no-op
// (RULE9) timer3 test: gated, skip, clear, else no-op
// (RULE10) ext0 pin test: polarity bit picks level
// (RULE11) ext1 pin test: polarity bit picks level
// (RULE12) powerdown test: skip if set, keep flag
// (RULE13) skipped instruction changes no state
// (RULE14) new set never lost to clear
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "skip_eval_regs.svh"
module skip_condition_evaluator
  import skip_eval_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // instruction sequencer
  input wire logic exec_valid_i,
  input wire logic [3:0] exec_op_i,
  input wire logic imm_valid_i,
  input wire logic [3:0] imm_i,
  input wire logic [3:0] acc_i,
  input wire logic [3:0] pointed_memory_nibble_i,
  output logic exec_skipped_o,
  output logic skip_valid_o,
  output logic skip_o,
  output logic skip_pending_o,
  // peripheral request sets and pins
  input wire logic [`FLAG_COUNT-1:0] flag_set_i,
  input wire logic ext0_pin_i,
  input wire logic ext1_pin_i,
  input wire logic powerdown_flag_i,
  // flag levels toward the core
  output logic [`FLAG_COUNT-1:0] request_flags_o
);
  ////////////////////////////////////////////////////////////////////////////
  // functions

  // one-hot flag that an op tests, zero for non-flag ops
  function automatic logic [`FLAG_COUNT-1:0] flag_mask(input logic [3:0] op);
    logic [`FLAG_COUNT-1:0] m;
    m = '0;
    unique case (op)
      OP_TEST_EXT0_REQUEST: m[`FLAG_EXT0] = 1'b1;
      OP_TEST_EXT1_REQUEST: m[`FLAG_EXT1] = 1'b1;
      OP_TEST_CONVERSION_DONE: m[`FLAG_CONV] = 1'b1;
      OP_TEST_SERIAL_DONE: m[`FLAG_SERIAL] = 1'b1;
      OP_TEST_TIMER1_REQUEST: m[`FLAG_TIMER1] = 1'b1;
      OP_TEST_TIMER2_REQUEST: m[`FLAG_TIMER2] = 1'b1;
      OP_TEST_TIMER3_REQUEST: m[`FLAG_TIMER3] = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction

  // enable bit that turns a flag test into a no-op
  function automatic logic gate_bit(input logic [3:0] op, input logic [3:0] c1, input logic [3:0] c2);
    logic g;
    g = 1'b0;
    unique case (op)
      OP_TEST_EXT0_REQUEST: g = c1[`EXT0_ENABLE_BIT];
      OP_TEST_EXT1_REQUEST: g = c1[`EXT1_ENABLE_BIT];
      OP_TEST_TIMER1_REQUEST: g = c1[`TIMER1_ENABLE_BIT];
      OP_TEST_TIMER2_REQUEST: g = c1[`TIMER2_ENABLE_BIT];
      OP_TEST_TIMER3_REQUEST: g = c2[`TIMER3_ENABLE_BIT];
      OP_TEST_CONVERSION_DONE: g = c2[`CONVERSION_ENABLE_BIT];
      OP_TEST_SERIAL_DONE: g = c2[`SERIAL_ENABLE_BIT];
      default: g = 1'b0;
    endcase
    return g;
  endfunction

  // byte-lane merge of a 4-bit control register
  function automatic logic [3:0] lane_write(input logic [3:0] old, input logic [31:0] d, input logic [3:0] sel);
    return sel[0] ? d[3:0] : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wishbone register file
  logic [3:0] irq_control_first_reg;
  logic [3:0] irq_control_second_reg;
  logic [3:0] ext0_control_reg;
  logic [3:0] ext1_control_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic skip_last_reg;
  logic skip_pending_reg;
  logic [`FLAG_COUNT-1:0] flags;

  // decode; one wait state, unmapped reads give zero
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  // write lands on the acknowledged edge, as the master sees it
  wire bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_reg;
  wire hit_ctrl1 = wb_adr_i == `IRQ_CONTROL_FIRST_OFS;
  wire hit_ctrl2 = wb_adr_i == `IRQ_CONTROL_SECOND_OFS;
  wire hit_ext0 = wb_adr_i == `EXT0_CONTROL_OFS;
  wire hit_ext1 = wb_adr_i == `EXT1_CONTROL_OFS;
  wire hit_flags = wb_adr_i == `FLAG_STATUS_OFS;
  wire hit_skip = wb_adr_i == `SKIP_STATUS_OFS;
  wire [31:0] rd_mux = hit_ctrl1 ? {28'h0000000, irq_control_first_reg} :
                       hit_ctrl2 ? {28'h0000000, irq_control_second_reg} :
                       hit_ext0 ? {28'h0000000, ext0_control_reg} :
                       hit_ext1 ? {28'h0000000, ext1_control_reg} :
                       hit_flags ? {25'h0, flags} :
                       hit_skip ? {30'h0, skip_last_reg, skip_pending_reg} : 32'h00000000;

  // control writes and registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_control_first_reg <= `CTRL_RESET;
      irq_control_second_reg <= `CTRL_RESET;
      ext0_control_reg <= `CTRL_RESET;
      ext1_control_reg <= `CTRL_RESET;
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h00000000;
    end else begin
      wb_ack_reg <= bus_req;
      wb_dat_reg <= bus_req ? rd_mux : 32'h00000000;
      if (bus_wr && hit_ctrl1) irq_control_first_reg <= lane_write(irq_control_first_reg, wb_dat_i, wb_sel_i);
      if (bus_wr && hit_ctrl2) irq_control_second_reg <= lane_write(irq_control_second_reg, wb_dat_i, wb_sel_i);
      if (bus_wr && hit_ext0) ext0_control_reg <= lane_write(ext0_control_reg, wb_dat_i, wb_sel_i);
      if (bus_wr && hit_ext1) ext1_control_reg <= lane_write(ext1_control_reg, wb_dat_i, wb_sel_i);
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  // bus handshake: one wait state, one-cycle ack, data only with ack
  chk_bus_ack_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged after one wait state");
  chk_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  chk_bus_data_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("bus read data not zero outside ack");

  ////////////////////////////////////////////////////////////////////////////
  // instruction evaluation
  eval_state_e state_reg;
  eval_state_e state_next;
  logic [3:0] acc_hold_reg;
  logic skip_valid_reg;
  logic skip_reg;

  // a skipped instruction is swallowed here and has no effect
  wire exec_skipped = exec_valid_i & skip_pending_reg; // [RULE13]
  wire take = exec_valid_i & ~skip_pending_reg & (state_reg == ST_IDLE);
  wire [`FLAG_COUNT-1:0] op_mask = flag_mask(exec_op_i);
  wire op_gate = gate_bit(exec_op_i, irq_control_first_reg, irq_control_second_reg);
  // gated test behaves as a no-op: no skip, no clear
  wire flag_hit = (|(op_mask & flags)) & ~op_gate; // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
  wire [`FLAG_COUNT-1:0] flag_clr = op_mask & {`FLAG_COUNT{take & flag_hit}}; // [RULE3] [RULE4] [RULE14]
  wire pin0_hit = ext0_control_reg[`EXT0_POLARITY_BIT] ? ext0_pin_i : ~ext0_pin_i; // [RULE10]
  wire pin1_hit = ext1_control_reg[`EXT1_POLARITY_BIT] ? ext1_pin_i : ~ext1_pin_i; // [RULE11]
  wire is_imm = exec_op_i == OP_SKIP_IF_ACC_EQUALS_IMM;
  wire imm_done = (state_reg == ST_WAIT_IMM) & imm_valid_i;
  wire imm_equal = acc_hold_reg == imm_i; // [RULE1]
  wire mem_equal = acc_i == pointed_memory_nibble_i; // [RULE2]
  // single-cycle decision; powerdown flag is only read, never cleared
  wire one_cycle_skip = (exec_op_i == OP_SKIP_IF_ACC_EQUALS_MEM) ? mem_equal :
                        (exec_op_i == OP_TEST_EXT0_PIN_LEVEL) ? pin0_hit :
                        (exec_op_i == OP_TEST_EXT1_PIN_LEVEL) ? pin1_hit :
                        (exec_op_i == OP_TEST_POWERDOWN_FLAG) ? powerdown_flag_i : flag_hit; // [RULE12]
  wire decide = (take & ~is_imm) | imm_done;
  wire decide_skip = imm_done ? imm_equal : one_cycle_skip;

  // two-word compare waits for its immediate word
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (take && is_imm) state_next = ST_WAIT_IMM; // [RULE1]
      ST_WAIT_IMM: if (imm_valid_i) state_next = ST_IDLE;
    endcase
  end

  // decision registers; pending skip consumed by the next instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      acc_hold_reg <= 4'h0;
      skip_valid_reg <= 1'b0;
      skip_reg <= 1'b0;
      skip_last_reg <= 1'b0;
      skip_pending_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (take && is_imm) acc_hold_reg <= acc_i;
      skip_valid_reg <= decide;
      skip_reg <= decide & decide_skip;
      if (decide) skip_last_reg <= decide_skip;
      if (decide) skip_pending_reg <= decide_skip;
      else if (exec_skipped) skip_pending_reg <= 1'b0; // [RULE13]
    end
  end

  // request flags
  request_flag_bank #(
    .WIDTH(`FLAG_COUNT)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(flag_set_i),
    .clr_i(flag_clr),
    .flags_o(flags)
  );

  assign exec_skipped_o = exec_skipped;
  assign skip_valid_o = skip_valid_reg;
  assign skip_o = skip_reg;
  assign skip_pending_o = skip_pending_reg;
  assign request_flags_o = flags;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_imm_compare_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    take && is_imm ##1 imm_valid_i |=> skip_valid_o && (skip_o == ($past(imm_i) == $past(acc_i, 2))))
    else $error("immediate compare skip wrong");
  chk_mem_compare_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    take && exec_op_i == OP_SKIP_IF_ACC_EQUALS_MEM |=> skip_valid_o && skip_o == $past(mem_equal))
    else $error("memory compare skip wrong");
  chk_ext0_skip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    take && exec_op_i == OP_TEST_EXT0_REQUEST && flags[`FLAG_EXT0] && !irq_control_first_reg[`EXT0_ENABLE_BIT]
    && !flag_set_i[`FLAG_EXT0] |=> skip_o && !flags[`FLAG_EXT0])
    else $error("ext0 test did not skip and clear");
  chk_gated_nop: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    take && |op_mask && op_gate |=> !skip_o &&
    ((flags & $past(op_mask)) == (($past(flags) | $past(flag_set_i)) & $past(op_mask))))
    else $error("gated flag test was not a no-op");
  chk_timer3_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    take && exec_op_i == OP_TEST_TIMER3_REQUEST |=>
    skip_o == ($past(flags[`FLAG_TIMER3]) && !$past(irq_control_second_reg[`TIMER3_ENABLE_BIT])))
    else $error("timer3 test gate wrong");
  chk_pin0_polarity: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    take && exec_op_i == OP_TEST_EXT0_PIN_LEVEL |=>
    skip_o == ($past(ext0_pin_i) == $past(ext0_control_reg[`EXT0_POLARITY_BIT])))
    else $error("ext0 pin polarity wrong");
  chk_powerdown_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    take && exec_op_i == OP_TEST_POWERDOWN_FLAG |=>
    skip_o == $past(powerdown_flag_i) && ($stable(flags) || |$past(flag_set_i)))
    else $error("powerdown test wrong");
  chk_skipped_inert: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    exec_skipped |-> flag_clr == '0 ##1 !skip_valid_o && !skip_pending_o)
    else $error("skipped instruction had an effect");
  chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    |(flag_set_i & flag_clr) |=> (flags & $past(flag_set_i)) == $past(flag_set_i))
    else $error("new request lost to clear");

  ////////////////////////////////////////////////////////////////////////////
  // flag tests with their enable bit clear skip and clear their own flag; ext1 pin test skips on the level its polarity bit picks
  chk_ext1_skip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    take && exec_op_i == OP_TEST_EXT1_REQUEST && flags[`FLAG_EXT1] && !irq_control_first_reg[`EXT1_ENABLE_BIT]
    && !flag_set_i[`FLAG_EXT1] |=> skip_o && !flags[`FLAG_EXT1])
    else $error("ext1 test did not skip and clear");
  chk_conv_skip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    take && exec_op_i == OP_TEST_CONVERSION_DONE && flags[`FLAG_CONV]
    && !irq_control_second_reg[`CONVERSION_ENABLE_BIT] && !flag_set_i[`FLAG_CONV] |=> skip_o && !flags[`FLAG_CONV])
    else $error("conversion test did not skip and clear");
  chk_serial_skip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    take && exec_op_i == OP_TEST_SERIAL_DONE && flags[`FLAG_SERIAL]
    && !irq_control_second_reg[`SERIAL_ENABLE_BIT] && !flag_set_i[`FLAG_SERIAL] |=> skip_o && !flags[`FLAG_SERIAL])
    else $error("serial test did not skip and clear");
  chk_timer1_skip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    take && exec_op_i == OP_TEST_TIMER1_REQUEST && flags[`FLAG_TIMER1]
    && !irq_control_first_reg[`TIMER1_ENABLE_BIT] && !flag_set_i[`FLAG_TIMER1] |=> skip_o && !flags[`FLAG_TIMER1])
    else $error("timer1 test did not skip and clear");
  chk_timer2_skip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    take && exec_op_i == OP_TEST_TIMER2_REQUEST && flags[`FLAG_TIMER2]
    && !irq_control_first_reg[`TIMER2_ENABLE_BIT] && !flag_set_i[`FLAG_TIMER2] |=> skip_o && !flags[`FLAG_TIMER2])
    else $error("timer2 test did not skip and clear");
  chk_pin1_polarity: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    take && exec_op_i == OP_TEST_EXT1_PIN_LEVEL |=>
    skip_o == ($past(ext1_pin_i) == $past(ext1_control_reg[`EXT1_POLARITY_BIT])))
    else $error("ext1 pin polarity wrong");

  // decision pulse shape; a clear flag never skips
  chk_unset_flag_noskip: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    take && |op_mask && !(|(op_mask & flags)) |=> !skip_o)
    else $error("flag test skipped on a clear flag");
  chk_imm_first_word: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    take && is_imm |=> !skip_valid_o)
    else $error("immediate compare decided before its second word");
  chk_skip_needs_valid: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    skip_o |-> skip_valid_o)
    else $error("skip shown without a decision");
  chk_pending_follows_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    skip_valid_o |-> skip_pending_o == skip_o)
    else $error("pending skip does not follow decision");
endmodule

// ==== design/skip_eval_pkg.sv ====
// types shared by the skip evaluator files
package skip_eval_pkg;
  typedef enum logic [3:0] {
    OP_SKIP_IF_ACC_EQUALS_IMM = 4'h0,
    OP_SKIP_IF_ACC_EQUALS_MEM = 4'h1,
    OP_TEST_EXT0_REQUEST = 4'h2,
    OP_TEST_EXT1_REQUEST = 4'h3,
    OP_TEST_CONVERSION_DONE = 4'h4,
    OP_TEST_SERIAL_DONE = 4'h5,
    OP_TEST_TIMER1_REQUEST = 4'h6,
    OP_TEST_TIMER2_REQUEST = 4'h7,
    OP_TEST_TIMER3_REQUEST = 4'h8,
    OP_TEST_EXT0_PIN_LEVEL = 4'h9,
    OP_TEST_EXT1_PIN_LEVEL = 4'hA,
    OP_TEST_POWERDOWN_FLAG = 4'hB,
    OP_OTHER = 4'hF
  } skip_op_e;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT_IMM = 1'b1
  } eval_state_e;
endpackage

// ==== design/skip_eval_regs.svh ====
// register offsets, field positions and reset values of the skip evaluator
`ifndef SKIP_EVAL_REGS_SVH
`define SKIP_EVAL_REGS_SVH
`define IRQ_CONTROL_FIRST_OFS 6'h00
`define IRQ_CONTROL_SECOND_OFS 6'h04
`define EXT0_CONTROL_OFS 6'h08
`define EXT1_CONTROL_OFS 6'h0C
`define FLAG_STATUS_OFS 6'h10
`define SKIP_STATUS_OFS 6'h14
`define CTRL_RESET 4'h0
`define EXT0_ENABLE_BIT 0
`define EXT1_ENABLE_BIT 1
`define TIMER1_ENABLE_BIT 2
`define TIMER2_ENABLE_BIT 3
`define TIMER3_ENABLE_BIT 0
`define CONVERSION_ENABLE_BIT 2
`define SERIAL_ENABLE_BIT 3
`define EXT0_POLARITY_BIT 2
`define EXT1_POLARITY_BIT 2
`define FLAG_EXT0 0
`define FLAG_EXT1 1
`define FLAG_TIMER1 2
`define FLAG_TIMER2 3
`define FLAG_TIMER3 4
`define FLAG_CONV 5
`define FLAG_SERIAL 6
`define FLAG_COUNT 7
`define SKIP_PENDING_BIT 0
`define SKIP_LAST_BIT 1
`endif
